/* File: rtl/lti_device.sv */
// Device end: registers, interrupt modes and open-drain interrupt of the sensor
// Assumes the host frames transfers on lti_link_if and conversions come from outside
`include "lti_params.svh"
module lti_device
  import lti_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `LTI_ADDR_A
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  lti_link_if.dev          link,
  input  wire logic        conv_done,
  input  wire logic [63:0] conv_data,
  output logic             int_active,
  output logic [7:0]       int_ctrl
);

  // Upper threshold resets to all ones so no crossing fires before setup
  localparam lti_dev_t DEV_RST = '{
    ctrl:    `LTI_CTRL_RST,
    src:     `LTI_SRC_RST,
    th_lo:   `LTI_THLO_RST,
    th_hi:   `LTI_THHI_RST,
    default: '0
  };

  ////////////////////////////////////////////////////////////////////////////
  // Refuse a target address the block cannot answer at
  if (DEV_ADDR != `LTI_ADDR_A && DEV_ADDR != `LTI_ADDR_B && DEV_ADDR != `LTI_ADDR_C)
  begin : g_bad_addr
    $error("DEV_ADDR must be one of the three target addresses");
  end

  // Working copies of the state record and decoded fields
  lti_dev_t    s_q;
  lti_dev_t    s_d;
  logic [1:0]  mode;
  logic [1:0]  mode_new;
  logic [1:0]  tr;
  logic        clr;
  logic        trig;
  logic        cmp_en;
  logic [15:0] chan_val;

  ////////////////////////////////////////////////////////////////////////////
  // Register read: unmapped offsets read as zero
  // A word read walks the pointer, so data offsets read low byte then high
  function automatic logic [7:0] reg_read(input lti_dev_t s, input logic [4:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == `LTI_REG_CTRL)
      v = s.ctrl;
    else if (a == `LTI_REG_SRC)
      v = s.src;
    else if (a == `LTI_REG_THLO_L)
      v = s.th_lo[7:0];
    else if (a == `LTI_REG_THLO_H)
      v = s.th_lo[15:8];
    else if (a == `LTI_REG_THHI_L)
      v = s.th_hi[7:0];
    else if (a == `LTI_REG_THHI_H)
      v = s.th_hi[15:8];
    else if ((a & `LTI_DATA_MASK) == `LTI_REG_DATA)
      v = s.data[{a[2:0], 3'h0} +: 8];
    return v;
  endfunction : reg_read

  ////////////////////////////////////////////////////////////////////////////
  // Register write: data registers are read only, others ignored
  // Thresholds take each byte as it arrives, so a cut word keeps the old high byte
  function automatic lti_dev_t reg_write(input lti_dev_t s, input logic [4:0] a,
                                         input logic [7:0] b);
    lti_dev_t r;
    r = s;
    unique case (a)
      `LTI_REG_CTRL:   r.ctrl = b;
      `LTI_REG_SRC:    r.src = b;
      `LTI_REG_THLO_L: r.th_lo[7:0] = b;
      `LTI_REG_THLO_H: r.th_lo[15:8] = b;
      `LTI_REG_THHI_L: r.th_hi[7:0] = b;
      `LTI_REG_THHI_H: r.th_hi[15:8] = b;
      default:         r = s;
    endcase
    return r;
  endfunction : reg_write

  ////////////////////////////////////////////////////////////////////////////
  // Channel chosen by the source register feeds the comparison
  assign mode     = s_q.ctrl[`LTI_MODE_HI:`LTI_MODE_LO];
  assign chan_val = conv_data[{s_q.src[1:0], 4'h0} +: 16];
  assign cmp_en   = (mode == `LTI_MODE_LEVEL) || (mode == `LTI_MODE_ALERT);

  // Filter only counts while a threshold style is active, never off or in test
  lti_persist u_persist
  (
    .clk    (clk),
    .rst_n  (rst_n),
    .en     (cmp_en),
    .sample (conv_done),
    .value  (chan_val),
    .th_lo  (s_q.th_lo),
    .th_hi  (s_q.th_hi),
    .code   (s_q.ctrl[`LTI_PERS_HI:`LTI_PERS_LO]),
    .trig   (trig)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Link handling, register access and interrupt state
  // Acknowledge and read valid are one-cycle pulses, the cycle after the strobe or read request
  always_comb
  begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.rvalid = 1'b0;
    clr = 1'b0;
    tr = link.wbyte[`LTI_TR_HI:`LTI_TR_LO];
    // Address byte opens a frame, repeated start keeps the pointer
    if (link.stb && link.start)
    begin
      s_d.sel = (link.wbyte[7:1] == DEV_ADDR);
      s_d.rd = link.wbyte[0];
      s_d.cmd_seen = 1'b0;
      s_d.ara = (link.wbyte[7:1] == `LTI_ARA_ADDR) && link.wbyte[0] &&
                s_q.int_act && (mode == `LTI_MODE_ALERT);
      s_d.ack = s_d.sel || s_d.ara;
    end
    // Command byte, then data bytes of a write
    else if (link.stb && s_q.sel && !s_q.rd)
    begin
      s_d.ack = 1'b1;
      if (!s_q.cmd_seen)
      begin
        s_d.cmd_seen = 1'b1;
        if (link.wbyte[`LTI_CMD_BIT])
        begin
          s_d.word = (tr == `LTI_TR_WORD);
          s_d.ptr = link.wbyte[4:0];
          clr = (tr == `LTI_TR_CLR) && (mode == `LTI_MODE_LEVEL);
        end
      end
      else
      begin
        s_d = reg_write(s_d, s_q.ptr, link.wbyte);
        s_d.ptr = s_q.ptr + {4'h0, s_q.word};
      end
    end
    // Register read, low byte first on a word
    else if (link.rreq && s_q.sel && s_q.rd)
    begin
      s_d.rvalid = 1'b1;
      s_d.rbyte = reg_read(s_q, s_q.ptr);
      s_d.ptr = s_q.ptr + {4'h0, s_q.word};
    end
    // Alert response returns our address and releases the line
    // Only answered while our interrupt is pending in alert style
    else if (link.rreq && s_q.ara)
    begin
      s_d.rvalid = 1'b1;
      s_d.rbyte = {DEV_ADDR, 1'b0};
      s_d.ara = 1'b0;
      clr = 1'b1;
    end
    // Stop ends the frame; a new address byte is needed before more access
    if (link.stop)
    begin
      s_d.sel = 1'b0;
      s_d.ara = 1'b0;
    end
    // Latest conversion result of all channels
    if (conv_done)
      s_d.data = conv_data;
    // Interrupt state per mode; a trigger beats a same-cycle clear
    // A trigger while off or in test is dropped, as the filter is gated
    mode_new = s_d.ctrl[`LTI_MODE_HI:`LTI_MODE_LO];
    case (mode_new)
      `LTI_MODE_OFF:  s_d.int_act = 1'b0;
      `LTI_MODE_TEST: s_d.int_act = 1'b1;
      default:
      begin
        if (trig && cmp_en)
          s_d.int_act = 1'b1;
        else if (clr)
          s_d.int_act = 1'b0;
      end
    endcase
  end

  // State register
  // Reset leaves control at zero, so no interrupt until the host sets a mode
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= DEV_RST;
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs: line only ever pulled low
  // The board pull-up sets the idle level of the shared interrupt line
  assign link.ack    = s_q.ack;
  assign link.rvalid = s_q.rvalid;
  assign link.rbyte  = s_q.rbyte;
  assign link.int_o  = 1'b0;
  assign link.int_oe = s_q.int_act;
  assign int_active  = s_q.int_act;
  assign int_ctrl    = s_q.ctrl;

endmodule : lti_device

/* File: rtl/lti_params.svh */
// Constants of the light threshold interrupt block: offsets, fields, resets, counts
// Assumes inclusion by bare name from every design file that needs them
//
// What this block does
// - Interrupt mode field selects interrupt behaviour.
// - Control value zero disables all interrupts.
// - Flag results above upper or below lower.
// - Compare only the channel the source selects.
// - Interrupt after persistence count of consecutive crossings.
// - Level and alert styles hold line low.
// - Command clear field 11b releases level interrupt.
// - Alert response releases alert-style interrupt only.
// - Persistence zero interrupts after every conversion.
// - End-of-conversion mode ignores both thresholds.
// - Mode 11 asserts interrupt at once, test.
// - Thresholds written as words, low byte first.
// - Command B0h word read returns channel one.
// - Device answers one of three target addresses.
// - Byte 24h to control selects alert, persistence.
// - Interrupt line open drain, only pulled low.
`ifndef LTI_PARAMS_SVH
`define LTI_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets inside the device
`define LTI_REG_CTRL    5'h02
`define LTI_REG_SRC     5'h03
`define LTI_REG_THLO_L  5'h08
`define LTI_REG_THLO_H  5'h09
`define LTI_REG_THHI_L  5'h0A
`define LTI_REG_THHI_H  5'h0B
`define LTI_REG_DATA    5'h10
`define LTI_DATA_MASK   5'h18

////////////////////////////////////////////////////////////////////////////////
// Command byte and control register fields
`define LTI_CMD_BIT     7
`define LTI_TR_HI       6
`define LTI_TR_LO       5
`define LTI_TR_WORD     2'h1
`define LTI_TR_CLR      2'h3
`define LTI_MODE_HI     5
`define LTI_MODE_LO     4
`define LTI_PERS_HI     2
`define LTI_PERS_LO     0
`define LTI_MODE_OFF    2'h0
`define LTI_MODE_LEVEL  2'h1
`define LTI_MODE_ALERT  2'h2
`define LTI_MODE_TEST   2'h3
`define LTI_PERS_EOC    3'h0

////////////////////////////////////////////////////////////////////////////////
// Addresses and reset values
`define LTI_ADDR_A      7'h39
`define LTI_ADDR_B      7'h29
`define LTI_ADDR_C      7'h49
`define LTI_ARA_ADDR    7'h0C
`define LTI_CTRL_RST    8'h00
`define LTI_SRC_RST     8'h00
`define LTI_THLO_RST    16'h0000
`define LTI_THHI_RST    16'hFFFF

////////////////////////////////////////////////////////////////////////////////
// Persistence counts in conversions per code, and host answer wait
`define LTI_PCNT_1      7'h01
`define LTI_PCNT_2      7'h02
`define LTI_PCNT_3      7'h05
`define LTI_PCNT_4      7'h19
`define LTI_PCNT_5      7'h32
`define LTI_PCNT_6      7'h4B
`define LTI_PCNT_7      7'h64
`define LTI_RSP_WAIT    2

`endif

/* File: rtl/lti_pkg.sv */
// Types of the light threshold interrupt block: state records and enumerations
// Assumes compilation before the interface and all modules
package lti_pkg;

  // Host requests
  typedef enum logic [2:0]
  {
    lti_op_wr_byte = 3'h0,
    lti_op_wr_word = 3'h1,
    lti_op_rd_byte = 3'h2,
    lti_op_rd_word = 3'h3,
    lti_op_int_clr = 3'h4,
    lti_op_alert   = 3'h5
  } lti_op_t;

  // Host sequencer states, one-hot
  typedef enum logic [8:0]
  {
    lti_hs_idle  = 9'h001,
    lti_hs_addr  = 9'h002,
    lti_hs_cmd   = 9'h004,
    lti_hs_d0    = 9'h008,
    lti_hs_d1    = 9'h010,
    lti_hs_raddr = 9'h020,
    lti_hs_r0    = 9'h040,
    lti_hs_r1    = 9'h080,
    lti_hs_stop  = 9'h100
  } lti_hstate_t;

  // Device state
  typedef struct packed
  {
    logic        sel;
    logic        rd;
    logic        ara;
    logic        cmd_seen;
    logic        word;
    logic [4:0]  ptr;
    logic [7:0]  ctrl;
    logic [7:0]  src;
    logic [15:0] th_lo;
    logic [15:0] th_hi;
    logic [63:0] data;
    logic        int_act;
    logic        ack;
    logic        rvalid;
    logic [7:0]  rbyte;
  } lti_dev_t;

  // Persistence filter state
  typedef struct packed
  {
    logic [6:0] cnt;
    logic       trig;
  } lti_pers_t;

  // Host state
  typedef struct packed
  {
    lti_hstate_t st;
    logic        wt;
    logic [1:0]  tmo;
    lti_op_t     op;
    logic [6:0]  addr;
    logic [7:0]  cmd;
    logic [15:0] wdata;
    logic        stb;
    logic        start;
    logic        stop;
    logic        rreq;
    logic [7:0]  wbyte;
    logic        busy;
    logic        done;
    logic        nack;
    logic [15:0] rdata;
    logic        irq;
  } lti_host_t;

endpackage : lti_pkg

/* File: rtl/lti_link_if.sv */
// Byte link between host and device, with the shared interrupt line
// Assumes a pull-up on the interrupt line, modelled by the resolution below
interface lti_link_if;

  logic       stb;
  logic       start;
  logic       stop;
  logic       rreq;
  logic [7:0] wbyte;
  logic       ack;
  logic       rvalid;
  logic [7:0] rbyte;
  logic       int_o;
  logic       int_oe;
  logic       int_n;

  // Wired-AND line: low only while the device enables a low drive
  assign int_n = !(int_oe && !int_o);

  modport dev
  (
    input  stb, start, stop, rreq, wbyte,
    output ack, rvalid, rbyte, int_o, int_oe
  );

  modport host
  (
    output stb, start, stop, rreq, wbyte,
    input  ack, rvalid, rbyte, int_n
  );

endinterface : lti_link_if

/* File: rtl/lti_persist.sv */
// Persistence filter: qualifies threshold crossings of one channel
// Assumes sample pulses once per finished conversion with value valid
`include "lti_params.svh"
module lti_persist
  import lti_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        en,
  input  wire logic        sample,
  input  wire logic [15:0] value,
  input  wire logic [15:0] th_lo,
  input  wire logic [15:0] th_hi,
  input  wire logic [2:0]  code,
  output logic             trig
);

  lti_pers_t  p_q;
  lti_pers_t  p_d;
  logic [6:0] need;

  ////////////////////////////////////////////////////////////////////////////
  // Conversions a crossing must last for each code
  always_comb
  begin
    case (code)
      3'h1:    need = `LTI_PCNT_1;
      3'h2:    need = `LTI_PCNT_2;
      3'h3:    need = `LTI_PCNT_3;
      3'h4:    need = `LTI_PCNT_4;
      3'h5:    need = `LTI_PCNT_5;
      3'h6:    need = `LTI_PCNT_6;
      3'h7:    need = `LTI_PCNT_7;
      default: need = `LTI_PCNT_1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count uninterrupted crossings, one trigger pulse per full run
  always_comb
  begin
    p_d = p_q;
    p_d.trig = 1'b0;
    if (!en)
    begin
      p_d.cnt = 7'h00;
    end
    else if (sample)
    begin
      if (code == `LTI_PERS_EOC)
      begin
        p_d.trig = 1'b1;
      end
      else if (value > th_hi || value < th_lo)
      begin
        if (p_q.cnt + 7'h01 >= need)
        begin
          p_d.trig = 1'b1;
          p_d.cnt = 7'h00;
        end
        else
        begin
          p_d.cnt = p_q.cnt + 7'h01;
        end
      end
      else
      begin
        p_d.cnt = 7'h00;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      p_q <= '0;
    else
      p_q <= p_d;
  end

  assign trig = p_q.trig;

endmodule : lti_persist

/* File: rtl/lti_host.sv */
// Host end: turns user requests into framed byte transfers on the link
// Assumes one device end on lti_link_if answering within the wait window
`include "lti_params.svh"
module lti_host
  import lti_pkg::*;
#(
  parameter int RSP_WAIT = `LTI_RSP_WAIT
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  lti_link_if.host         link,
  input  wire logic        req,
  input  wire lti_op_t     req_op,
  input  wire logic [6:0]  req_addr,
  input  wire logic [7:0]  req_cmd,
  input  wire logic [15:0] req_wdata,
  output logic             busy,
  output logic             done,
  output logic             nack,
  output logic [15:0]      rdata,
  output logic             irq
);

  // Refuse a wait the two-bit timer cannot count
  if (RSP_WAIT < 1 || RSP_WAIT > 3)
  begin : g_bad_wait
    $error("RSP_WAIT must lie between 1 and 3");
  end

  localparam logic [1:0] WAIT_LIM = RSP_WAIT[1:0];

  lti_host_t h_q;
  lti_host_t h_d;
  logic      resp;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: issue a byte, await its answer, then move on
  always_comb
  begin
    h_d = h_q;
    h_d.stb = 1'b0;
    h_d.start = 1'b0;
    h_d.stop = 1'b0;
    h_d.rreq = 1'b0;
    h_d.done = 1'b0;
    h_d.irq = !link.int_n;
    resp = link.ack || link.rvalid;
    unique case (h_q.st)
      lti_hs_idle:
      begin
        if (req)
        begin
          h_d.op = req_op;
          h_d.addr = req_addr;
          h_d.cmd = req_cmd;
          h_d.wdata = req_wdata;
          h_d.busy = 1'b1;
          h_d.nack = 1'b0;
          h_d.wt = 1'b0;
          h_d.st = (req_op == lti_op_alert) ? lti_hs_raddr : lti_hs_addr;
        end
      end
      lti_hs_addr, lti_hs_cmd, lti_hs_d0, lti_hs_d1, lti_hs_raddr, lti_hs_r0, lti_hs_r1:
      begin
        if (!h_q.wt)
        begin
          h_d.wt = 1'b1;
          h_d.tmo = 2'h0;
          h_d.stb = !(h_q.st == lti_hs_r0 || h_q.st == lti_hs_r1);
          h_d.rreq = !h_d.stb;
          h_d.start = (h_q.st == lti_hs_addr) || (h_q.st == lti_hs_raddr);
          if (h_q.st == lti_hs_addr)
            h_d.wbyte = {h_q.addr, 1'b0};
          else if (h_q.st == lti_hs_raddr)
            h_d.wbyte = {(h_q.op == lti_op_alert) ? `LTI_ARA_ADDR : h_q.addr, 1'b1};
          else if (h_q.st == lti_hs_cmd)
            h_d.wbyte = h_q.cmd;
          else if (h_q.st == lti_hs_d0)
            h_d.wbyte = h_q.wdata[7:0];
          else
            h_d.wbyte = h_q.wdata[15:8];
        end
        else if (resp)
        begin
          h_d.wt = 1'b0;
          if (h_q.st == lti_hs_r0)
            h_d.rdata = {8'h00, link.rbyte};
          if (h_q.st == lti_hs_r1)
            h_d.rdata[15:8] = link.rbyte;
          if (h_q.st == lti_hs_addr)
            h_d.st = lti_hs_cmd;
          else if (h_q.st == lti_hs_cmd)
            h_d.st = (h_q.op == lti_op_int_clr) ? lti_hs_stop :
                     (h_q.op == lti_op_rd_byte || h_q.op == lti_op_rd_word) ?
                     lti_hs_raddr : lti_hs_d0;
          else if (h_q.st == lti_hs_d0)
            h_d.st = (h_q.op == lti_op_wr_word) ? lti_hs_d1 : lti_hs_stop;
          else if (h_q.st == lti_hs_raddr)
            h_d.st = lti_hs_r0;
          else if (h_q.st == lti_hs_r0)
            h_d.st = (h_q.op == lti_op_rd_word) ? lti_hs_r1 : lti_hs_stop;
          else
            h_d.st = lti_hs_stop;
        end
        else if (h_q.tmo == WAIT_LIM)
        begin
          h_d.wt = 1'b0;
          h_d.nack = 1'b1;
          h_d.st = lti_hs_stop;
        end
        else
        begin
          h_d.tmo = h_q.tmo + 2'h1;
        end
      end
      lti_hs_stop:
      begin
        h_d.stop = 1'b1;
        h_d.busy = 1'b0;
        h_d.done = 1'b1;
        h_d.st = lti_hs_idle;
      end
      default:
      begin
        h_d.st = lti_hs_idle;
        h_d.busy = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      h_q <= '{st: lti_hs_idle, op: lti_op_wr_byte, default: '0};
    else
      h_q <= h_d;
  end

  // Outputs straight from the state register
  assign link.stb   = h_q.stb;
  assign link.start = h_q.start;
  assign link.stop  = h_q.stop;
  assign link.rreq  = h_q.rreq;
  assign link.wbyte = h_q.wbyte;
  assign busy       = h_q.busy;
  assign done       = h_q.done;
  assign nack       = h_q.nack;
  assign rdata      = h_q.rdata;
  assign irq        = h_q.irq;

endmodule : lti_host

/* File: testbench/lti_link_props.sv */
// Assertions on the byte link and interrupt line between host and device ends
// Assumes the signals of lti_link_if as plain inputs, one clock, reset active low
module lti_link_props
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       stb,
  input wire logic       start,
  input wire logic       stop,
  input wire logic       rreq,
  input wire logic       ack,
  input wire logic       rvalid,
  input wire logic [7:0] rbyte,
  input wire logic       int_o,
  input wire logic       int_oe
);
  // One clock domain, reset disables all checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  // Framing and answers on the link
  a_start_has_byte: assert property (start |-> stb)
    else $error("Address mark without byte strobe");
  a_stop_alone: assert property (stop |-> !stb && !rreq)
    else $error("Stop overlaps a transfer");
  a_read_answered: assert property (rreq |=> rvalid && !rreq)
    else $error("Read request not answered next cycle");
  a_ack_has_cause: assert property (ack |-> $past(stb))
    else $error("Acknowledge without a byte");
  a_rvalid_has_cause: assert property (rvalid |-> $past(rreq))
    else $error("Read byte without request");
  a_rbyte_holds: assert property (!rvalid |-> $stable(rbyte))
    else $error("Read byte changed outside a read");

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt line
  a_line_low_only: assert property (int_oe |-> !int_o)
    else $error("Interrupt line driven high");
  a_int_held: assert property (int_oe && !ack && !rvalid |=> int_oe || ack || rvalid)
    else $error("Interrupt released without a clear");
endmodule : lti_link_props

/* File: testbench/test_light_threshold_interrupt.sv */
// Bench joining host and device ends, checked against a model of the interrupt rules
// Assumes the design files and lti_link_props are compiled before this file
module test_light_threshold_interrupt
  import lti_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [6:0] ADDR = 7'h39;
  logic        clk, rst_n, req, conv_done, busy, done, nack, irq, int_active, pend;
  lti_op_t     req_op;
  logic [6:0]  req_addr;
  logic [7:0]  req_cmd, int_ctrl, ctrl;
  logic [15:0] req_wdata, rdata, th_lo, th_hi, ch1;
  logic [63:0] conv_data;
  logic [1:0]  src;
  logic [6:0]  pt [7] = '{7'h01, 7'h02, 7'h05, 7'h19, 7'h32, 7'h4B, 7'h64};
  int          cnt, failures, num_checks, p;

  ////////////////////////////////////////////////////////////////////////////////
  // Both ends on one link, checker beside it
  lti_link_if link ();
  lti_host i_lti_host (.clk(clk), .rst_n(rst_n), .link(link), .req(req), .req_op(req_op),
    .req_addr(req_addr), .req_cmd(req_cmd), .req_wdata(req_wdata), .busy(busy),
    .done(done), .nack(nack), .rdata(rdata), .irq(irq));
  lti_device i_lti_device (.clk(clk), .rst_n(rst_n), .link(link), .conv_done(conv_done),
    .conv_data(conv_data), .int_active(int_active), .int_ctrl(int_ctrl));
  lti_link_props i_lti_link_props (.clk(clk), .rst_n(rst_n), .stb(link.stb),
    .start(link.start), .stop(link.stop), .rreq(link.rreq), .ack(link.ack),
    .rvalid(link.rvalid), .rbyte(link.rbyte), .int_o(link.int_o), .int_oe(link.int_oe));

  // Clock of 100 ns
  always #50 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, comparison and stimulus tasks
  task stop_test;
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One host request, waits for done under a bound
  task hreq(input lti_op_t op, input logic [6:0] a, input logic [7:0] c, input logic [15:0] d);
    int n;
    @(posedge clk);
    req       <= 1'b1;
    req_op    <= op;
    req_addr  <= a;
    req_cmd   <= c;
    req_wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
      if (done !== 1'b1)
        chk({15'h0000, busy}, 16'h0001);
    end
    while (done !== 1'b1 && n < 100);
    chk({15'h0000, done}, 16'h0001);
    chk({15'h0000, busy}, 16'h0000);
  endtask : hreq

  // Line, pending flag and host view against the model
  task cmp;
    chk({15'h0000, link.int_n}, {15'h0000, ~pend});
    chk({15'h0000, int_active}, {15'h0000, pend});
    @(posedge clk);
    #1;
    chk({15'h0000, irq}, {15'h0000, pend});
  endtask : cmp

  task setc(input logic [7:0] v);
    hreq(lti_op_wr_byte, ADDR, 8'h82, {8'h00, v});
    ctrl = v;
    if (v[5:4] == 2'h3)
      pend = 1'b1;
    if (v[5:4] == 2'h0)
    begin
      pend = 1'b0;
      cnt = 0;
    end
    chk({8'h00, int_ctrl}, {8'h00, ctrl});
    cmp();
  endtask : setc

  task clr(input lti_op_t op);
    hreq(op, ADDR, 8'hE0, 16'h0000);
    if (op == lti_op_int_clr && ctrl[5:4] == 2'h1)
      pend = 1'b0;
    if (op == lti_op_alert)
    begin
      pend = 1'b0;
      chk(rdata, {8'h00, ADDR, 1'b0});
    end
    cmp();
  endtask : clr

  // One conversion, selected channel carries v, model updated
  task conv(input logic [15:0] v);
    logic [63:0] d;
    d = {$urandom, $urandom};
    d[src * 16 +: 16] = v;
    ch1 = d[15:0];
    @(posedge clk);
    conv_done <= 1'b1;
    conv_data <= d;
    @(posedge clk);
    conv_done <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    if (ctrl[5:4] == 2'h0)
      cnt = 0;
    else if (ctrl[2:0] == 3'h0)
      pend = 1'b1;
    else if (v > th_hi || v < th_lo)
    begin
      cnt++;
      if (cnt == pt[ctrl[2:0] - 3'h1])
      begin
        pend = 1'b1;
        cnt = 0;
      end
    end
    else
      cnt = 0;
    cmp();
  endtask : conv

  function automatic logic [15:0] out();
    return $urandom_range(1) ? th_hi + 16'h0001 : th_lo - 16'h0001;
  endfunction : out

  // Broken run of crossings, then a full run
  task runp(input int n);
    for (int i = 1; i < n; i++)
      conv(out());
    conv(th_lo);
    for (int i = 0; i < n; i++)
      conv(out());
  endtask : runp

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    req = 1'b0;
    req_op = lti_op_wr_byte;
    req_addr = 7'h00;
    req_cmd = 8'h00;
    req_wdata = 16'h0000;
    conv_done = 1'b0;
    conv_data = 64'h0000000000000000;
    failures = 0;
    num_checks = 0;
    cnt = 0;
    pend = 1'b0;
    ctrl = 8'h00;
    void'($urandom(32'hA697));
    th_lo = {8'h10, 8'($urandom)};
    th_hi = {8'hC0, 8'($urandom)};
    src = 2'($urandom);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    hreq(lti_op_wr_word, ADDR, 8'hA8, th_lo);
    hreq(lti_op_wr_word, ADDR, 8'hAA, th_hi);
    hreq(lti_op_rd_word, ADDR, 8'hA8, 16'h0000);
    chk(rdata, th_lo);
    hreq(lti_op_rd_word, ADDR, 8'hAA, 16'h0000);
    chk(rdata, th_hi);
    hreq(lti_op_wr_byte, ADDR, 8'h83, {14'h0000, src});
    hreq(lti_op_rd_byte, ADDR, 8'h83, 16'h0000);
    chk(rdata, {14'h0000, src});
    for (p = 1; p < 8; p++)
    begin
      setc({5'h02, 3'(p)});
      runp(pt[p - 1]);
      clr(lti_op_int_clr);
      setc(8'h00);
    end
    setc(8'h10);
    conv(th_lo);
    clr(lti_op_int_clr);
    setc(8'h20);
    conv(th_hi);
    clr(lti_op_int_clr);
    clr(lti_op_alert);
    setc(8'h24);
    runp(pt[3]);
    clr(lti_op_int_clr);
    clr(lti_op_alert);
    setc(8'h00);
    conv(out());
    hreq(lti_op_rd_word, ADDR, 8'hB0, 16'h0000);
    chk(rdata, ch1);
    setc(8'h30);
    setc(8'h00);
    conv(out());
    hreq(lti_op_wr_byte, 7'h29, 8'h82, 16'h0031);
    chk({15'h0000, nack}, 16'h0001);
    chk({8'h00, int_ctrl}, {8'h00, ctrl});
    stop_test();
  end
endmodule : test_light_threshold_interrupt
